// ### mcor_pkg.sv
package mcor_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [31:0] MCOR_BOARD_CTRL_ADDR = 32'h1FBD9878;
    localparam logic [7:0] MCOR_BOARD_CTRL_RST = 8'h00;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int MCOR_BIT_MARGIN_UP = 7;
    localparam int MCOR_BIT_MARGIN_DOWN = 6;
    localparam int MCOR_BIT_SERIAL_A = 5;
    localparam int MCOR_BIT_SERIAL_B = 4;
    localparam int MCOR_BIT_AUTO_MEDIA = 3;
    localparam int MCOR_BIT_MEDIA_SEL = 2;
    localparam int MCOR_BIT_TERM_SEL = 1;
    localparam int MCOR_BIT_SQUELCH = 0;
    // ----------------------------------------------------------------
    // input synchroniser
    // ----------------------------------------------------------------
    localparam int MCOR_SYNC_STAGES = 3;
endpackage : mcor_pkg

// ### mcor_sync.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// three-stage synchroniser, change accepted when stages two and three agree
// ----------------------------------------------------------------
module mcor_sync
    import mcor_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_r, s2_r, s3_r, q_r;
    logic [WIDTH-1:0] q_nxt;

    always_comb begin
        q_nxt = q_r;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                q_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            q_r <= INIT;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end

    assign dout = q_r;
endmodule : mcor_sync

// ### mcor_top.sv
`timescale 1ns/100ps
module mcor_top
    import mcor_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic device_select_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [ADDR_W-1:0] p_addr,
    input wire logic [7:0] p_data_in,
    output logic [7:0] p_data_out,
    output logic p_data_oe,
    output logic margin_up,
    output logic margin_down,
    output logic serial_a_line_standard,
    output logic serial_b_line_standard,
    output logic eth_auto_media,
    output logic eth_media_sel,
    output logic eth_termination_sel,
    output logic eth_squelch_reduce
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // the host keeps address and data stable long around the strobe,
    // so a sampled strobe edge sees settled address and data
    logic [2:0] strb_s;
    logic [ADDR_W+7:0] ad_s;

    mcor_sync #(.WIDTH(3), .INIT(3'h7)) u_sync_strb (
        .clock(clock),
        .nrst(nrst),
        .din({device_select_n, rd_n, wr_n}),
        .dout(strb_s)
    );

    mcor_sync #(.WIDTH(ADDR_W + 8), .INIT('0)) u_sync_ad (
        .clock(clock),
        .nrst(nrst),
        .din({p_addr, p_data_in}),
        .dout(ad_s)
    );

    logic cs_n_s, rd_n_s, wr_n_s;
    logic [ADDR_W-1:0] addr_s;
    logic [7:0] wdata_s;
    logic hit;
    assign cs_n_s = strb_s[2];
    assign rd_n_s = strb_s[1];
    assign wr_n_s = strb_s[0];
    assign addr_s = ad_s[ADDR_W+7:8];
    assign wdata_s = ad_s[7:0];
    assign hit = !cs_n_s && (addr_s == MCOR_BOARD_CTRL_ADDR[ADDR_W-1:0]);

    // ----------------------------------------------------------------
    // control register and read path
    // ----------------------------------------------------------------
    logic [7:0] ctrl_r, ctrl_nxt;
    logic wr_n_d_r, wr_n_d_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic oe_r, oe_nxt;

    always_comb begin
        ctrl_nxt = ctrl_r;
        wr_n_d_nxt = wr_n_s;
        // one load per strobe, on its falling edge; data is already settled
        if (hit && !wr_n_s && wr_n_d_r) begin
            ctrl_nxt = wdata_s;
        end
        // read only drives the bus, the register is untouched
        oe_nxt = hit && !rd_n_s && wr_n_s;
        rdata_nxt = oe_nxt ? ctrl_r : 8'h00;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctrl_r <= MCOR_BOARD_CTRL_RST;
            wr_n_d_r <= 1'b1;
            rdata_r <= 8'h00;
            oe_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            wr_n_d_r <= wr_n_d_nxt;
            rdata_r <= rdata_nxt;
            oe_r <= oe_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs, each control pin straight from the control register, the bus pins from the read registers
    // ----------------------------------------------------------------
    assign margin_up = ctrl_r[MCOR_BIT_MARGIN_UP];
    assign margin_down = ctrl_r[MCOR_BIT_MARGIN_DOWN];
    assign serial_a_line_standard = ctrl_r[MCOR_BIT_SERIAL_A];
    assign serial_b_line_standard = ctrl_r[MCOR_BIT_SERIAL_B];
    assign eth_auto_media = ctrl_r[MCOR_BIT_AUTO_MEDIA];
    // passed through as is; the transceiver ignores it in automatic mode
    assign eth_media_sel = ctrl_r[MCOR_BIT_MEDIA_SEL];
    assign eth_termination_sel = ctrl_r[MCOR_BIT_TERM_SEL];
    assign eth_squelch_reduce = ctrl_r[MCOR_BIT_SQUELCH];
    assign p_data_out = rdata_r;
    assign p_data_oe = oe_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_write_edge;
        hit && !wr_n_s && wr_n_d_r;
    endsequence

    sequence s_read_cycle;
        hit && !rd_n_s && wr_n_s;
    endsequence

    sequence s_no_write_edge;
        !(hit && !wr_n_s && wr_n_d_r);
    endsequence

    // a strobe still low one cycle after its load
    sequence s_strobe_held;
        s_write_edge ##1 !wr_n_s;
    endsequence

    // a read followed by its strobe or select going away
    sequence s_read_release;
        s_read_cycle ##1 !(hit && !rd_n_s && wr_n_s);
    endsequence

    a_write_loads: assert property (@(posedge clock) disable iff (!nrst)
        s_write_edge |=> (ctrl_r == $past(wdata_s)))
        else $error("control register missed a write");

    a_hold_idle: assert property (@(posedge clock) disable iff (!nrst)
        !(hit && !wr_n_s && wr_n_d_r) |=> $stable(ctrl_r))
        else $error("control register changed without a write");

    a_read_data: assert property (@(posedge clock) disable iff (!nrst)
        s_read_cycle |=> (p_data_oe && p_data_out == $past(ctrl_r)))
        else $error("read returned wrong data");

    a_no_stray_drive: assert property (@(posedge clock) disable iff (!nrst)
        !(hit && !rd_n_s && wr_n_s) |=> !p_data_oe)
        else $error("data bus driven outside a read");

    a_margin_up: assert property (@(posedge clock) disable iff (!nrst)
        s_write_edge |=> (margin_up == $past(wdata_s[MCOR_BIT_MARGIN_UP])))
        else $error("margin up not following bit 7");

    a_margin_down: assert property (@(posedge clock) disable iff (!nrst)
        s_write_edge |=> (margin_down == $past(wdata_s[MCOR_BIT_MARGIN_DOWN])))
        else $error("margin down not following bit 6");

    a_serial_std: assert property (@(posedge clock) disable iff (!nrst)
        s_write_edge |=> (serial_a_line_standard == $past(wdata_s[MCOR_BIT_SERIAL_A])
            && serial_b_line_standard == $past(wdata_s[MCOR_BIT_SERIAL_B])))
        else $error("serial line standard bits wrong");

    a_eth_bits: assert property (@(posedge clock) disable iff (!nrst)
        s_write_edge |=> ({eth_auto_media, eth_media_sel, eth_termination_sel,
            eth_squelch_reduce} == $past(wdata_s[3:0])))
        else $error("ethernet control bits wrong");

    a_reset_clear: assert property (@(posedge clock)
        !nrst |=> (ctrl_r == 8'h00 && !p_data_oe))
        else $error("outputs not cleared by reset");

    // a long strobe must not reload, or a slow data edge could land twice
    a_single_load: assert property (@(posedge clock) disable iff (!nrst)
        s_strobe_held |=> $stable(ctrl_r))
        else $error("control register loaded twice in one strobe");

    // other addresses and a released select are ignored
    a_write_refused: assert property (@(posedge clock) disable iff (!nrst)
        (!wr_n_s && !hit) |=> $stable(ctrl_r))
        else $error("control register took a foreign write");

    a_read_release: assert property (@(posedge clock) disable iff (!nrst)
        s_read_release |=> (!p_data_oe && p_data_out == 8'h00))
        else $error("data bus still driven after read ended");

    a_read_no_effect: assert property (@(posedge clock) disable iff (!nrst)
        s_read_cycle |=> $stable(ctrl_r))
        else $error("read disturbed the control register");

    // write wins over read, so the bus is never driven against the host
    a_read_wr_clash: assert property (@(posedge clock) disable iff (!nrst)
        (hit && !rd_n_s && !wr_n_s) |=> !p_data_oe)
        else $error("data bus driven during a write");

    a_idle_data_zero: assert property (@(posedge clock) disable iff (!nrst)
        !p_data_oe |-> (p_data_out == 8'h00))
        else $error("read data not zero while bus released");

    a_supply_hold: assert property (@(posedge clock) disable iff (!nrst)
        s_no_write_edge |=> $stable({margin_up, margin_down, serial_a_line_standard,
            serial_b_line_standard}))
        else $error("supply or serial output changed without a write");

    a_eth_hold: assert property (@(posedge clock) disable iff (!nrst)
        s_no_write_edge |=> $stable({eth_auto_media, eth_media_sel, eth_termination_sel,
            eth_squelch_reduce}))
        else $error("ethernet output changed without a write");

    a_reset_pins: assert property (@(posedge clock)
        !nrst |=> ({margin_up, margin_down, serial_a_line_standard, serial_b_line_standard,
            eth_auto_media, eth_media_sel, eth_termination_sel, eth_squelch_reduce}
            == MCOR_BOARD_CTRL_RST && p_data_out == 8'h00))
        else $error("control outputs not cleared by reset");
endmodule : mcor_top

// ### mcor_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// host bus controller, timing counted in 8 ns clocks
// ----------------------------------------------------------------
module mcor_host_model (
    input wire logic clock,
    output logic device_select_n,
    output logic rd_n,
    output logic wr_n,
    output logic [31:0] p_addr,
    output logic [7:0] p_data_in,
    input wire logic [7:0] p_data_out,
    input wire logic p_data_oe
);
    initial begin
        device_select_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        p_addr = 32'h00000000;
        p_data_in = 8'h00;
    end
    // idle lines show inverted values so a stale match cannot pass
    task automatic xfer(input logic [31:0] a, input logic [7:0] d, input logic rd,
                        output logic [8:0] rv);
        @(negedge clock);
        device_select_n = 1'b0;
        p_addr = a;
        p_data_in = rd ? ~p_data_in : d;
        repeat (8) @(negedge clock);
        if (rd) rd_n = 1'b0;
        else wr_n = 1'b0;
        // read data settles long before the strobe ends; take it at the release edge
        repeat (23) @(negedge clock);
        rv = {p_data_oe, p_data_out};
        rd_n = 1'b1;
        wr_n = 1'b1;
        repeat (4) @(negedge clock);
        device_select_n = 1'b1;
        p_addr = ~p_addr;
        p_data_in = ~p_data_in;
        repeat (64) @(negedge clock);
    endtask : xfer
endmodule : mcor_host_model

// ### test_mcor_top.sv
`timescale 1ns/100ps
module test_mcor_top;
    import mcor_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic device_select_n, rd_n, wr_n, p_data_oe;
    logic [31:0] p_addr;
    logic [7:0] p_data_in, p_data_out, pat;
    wire [7:0] ctl;
    logic [8:0] rv;
    int err_total = 0;
    int checks_done = 0;
    always #4 clock = ~clock;
    mcor_top i_mcor_top (.clock(clock), .nrst(nrst), .device_select_n(device_select_n),
        .rd_n(rd_n), .wr_n(wr_n), .p_addr(p_addr), .p_data_in(p_data_in),
        .p_data_out(p_data_out), .p_data_oe(p_data_oe), .margin_up(ctl[7]),
        .margin_down(ctl[6]), .serial_a_line_standard(ctl[5]),
        .serial_b_line_standard(ctl[4]), .eth_auto_media(ctl[3]),
        .eth_media_sel(ctl[2]), .eth_termination_sel(ctl[1]), .eth_squelch_reduce(ctl[0]));
    mcor_host_model i_mcor_host_model (.clock(clock), .device_select_n(device_select_n),
        .rd_n(rd_n), .wr_n(wr_n), .p_addr(p_addr), .p_data_in(p_data_in),
        .p_data_out(p_data_out), .p_data_oe(p_data_oe));
    // ----------------------------------------------------------------
    // compare and verdict
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    task automatic do_reset;
        nrst = 1'b0;
        repeat (12) @(negedge clock);
        nrst = 1'b1;
        repeat (6) @(negedge clock);
    endtask : do_reset
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        do_reset();
        check(ctl, MCOR_BOARD_CTRL_RST);
        i_mcor_host_model.xfer(MCOR_BOARD_CTRL_ADDR, 8'h00, 1'b1, rv);
        check(rv[7:0], 8'h00);
        check({7'h00, rv[8]}, 8'h01);
        $display("test reset_values done");
        // walking one then walking zero, so each bit is seen set and cleared alone
        for (int i = 0; i < 16; i++) begin
            pat = (i < 8) ? 8'h01 << i : ~(8'h01 << (i - 8));
            i_mcor_host_model.xfer(MCOR_BOARD_CTRL_ADDR, pat, 1'b0, rv);
            check(ctl, pat);
            i_mcor_host_model.xfer(MCOR_BOARD_CTRL_ADDR, 8'h00, 1'b1, rv);
            check(rv[7:0], pat);
            check(ctl, pat);
        end
        $display("test bit_walk done");
        i_mcor_host_model.xfer(MCOR_BOARD_CTRL_ADDR + 32'h00000004, 8'h5A, 1'b0, rv);
        check(ctl, 8'h7F);
        i_mcor_host_model.xfer(MCOR_BOARD_CTRL_ADDR ^ 32'h80000000, 8'h00, 1'b0, rv);
        check(ctl, 8'h7F);
        i_mcor_host_model.xfer(MCOR_BOARD_CTRL_ADDR ^ 32'h80000000, 8'h00, 1'b1, rv);
        check(rv[7:0], 8'h00);
        check({7'h00, rv[8]}, 8'h00);
        $display("test unmapped done");
        i_mcor_host_model.xfer(MCOR_BOARD_CTRL_ADDR, 8'hFF, 1'b0, rv);
        check(ctl, 8'hFF);
        do_reset();
        check(ctl, MCOR_BOARD_CTRL_RST);
        i_mcor_host_model.xfer(MCOR_BOARD_CTRL_ADDR, 8'h00, 1'b1, rv);
        check(rv[7:0], MCOR_BOARD_CTRL_RST);
        $display("test mid_reset done");
        close_out();
    end
    initial begin
        #200000;
        err_total++;
        close_out();
    end
endmodule : test_mcor_top
